//--- design/averager_pkg.sv
/*
 Shared types and constants for the windowed input averager.
 Assumes samples are signed display counts, one per valid beat.
*/
package averager_pkg;
   localparam int SAMPLE_W      = 24;
   localparam int CHANNELS      = 4;
   localparam int CH_W          = 2;
   localparam int COUNT_W       = 8;
   localparam int WIDTH_W       = 16;
   localparam int FIFO_DEPTH    = 8;
   localparam int SUM_W         = SAMPLE_W + COUNT_W;
   localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h01;
   localparam logic [WIDTH_W-1:0] WIDTH_RESET = 16'hFFFF;
   localparam logic [3:0]         SEL_DIGIT_BASE = 4'h1;

   // One sample with its channel tag
   typedef struct packed {
      logic [CH_W-1:0]            chan;
      logic signed [SAMPLE_W-1:0] value;
   } sample_type;

   // Output value with its averaged flag
   typedef struct packed {
      logic [CH_W-1:0]            chan;
      logic                       averaged;
      logic signed [SAMPLE_W-1:0] value;
   } result_type;

   // Configuration write: last digit of the selection code picks the channel
   typedef struct packed {
      logic [3:0]         sel_digit;
      logic [COUNT_W-1:0] avg_sample_count;
      logic [WIDTH_W-1:0] avg_window_width;
   } config_type;
endpackage : averager_pkg

//--- design/sample_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock and an active-high asynchronous reset.
*/
`timescale 1ns/1ps
module sample_fifo #(
   parameter int WIDTH = 26,
   parameter int DEPTH = 8
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
   end

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0]      wr_r;
   logic [AW:0]      rd_r;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   // Honest full and empty from pointer comparison
   assign in_ready  = (wr_r - rd_r) != (AW+1)'(DEPTH);
   assign out_valid = wr_r != rd_r;
   assign out_data  = mem_r[rd_r[AW-1:0]];

   // Storage
   always_ff @(posedge clock) begin
      if (push) mem_r[wr_r[AW-1:0]] <= in_data;
   end

   // Pointers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (push) wr_r <= wr_r + 1'b1;
         if (pop) rd_r <= rd_r + 1'b1;
      end
   end
endmodule // sample_fifo

//--- design/windowed_input_averager.sv
/*
 Per-channel windowed averaging filter with an input FIFO.

 Data path
   Samples enter through an eight word FIFO, so the front end may offer
   them back to back while the sink stalls. One sample leaves the FIFO
   per cycle, and only when the output register is empty or being read.
   Each sample carries its channel tag. The filter state of that channel
   is read, the result is worked out in the same cycle, and the result is
   registered together with a flag that tells whether it was averaged.

 Per-channel state
   count    number of samples in the running average
   width    window width in display counts
   ring     the last 256 samples, written at head
   fill     samples since the average restarted, capped at count
   sum      running sum of the samples in the average
   centre   centre of the current window
   last     previous sample, used to judge settling
   unset    high while no window is set for the channel

 Window decisions
   A sample inside the window (distance to the centre at most half the
   width) joins the running average, and the average is output.
   A sample outside the window is output raw. If it lies within one width
   of the previous sample, the signal is taken as settled, a new window is
   centred on it and the average restarts from it. Otherwise the channel is
   left without a window and every sample is output raw until two
   successive samples lie within one width of each other.

 Running sum
   The sum is kept by adding the new sample and, once the average is full,
   subtracting the sample that leaves it, read from the ring. The sum is
   wide enough for 255 full scale samples of either sign, so it never
   wraps. The quotient truncates toward zero.

 Configuration
   A write with a zero count or a zero width, or whose digit selects no
   channel, is ignored. A valid write restarts the selected channel with
   no window, so stale samples of the old setting never mix into the new
   average. Channel tags beyond the channel count pass through raw and
   touch no state.

 Limitations
   A configuration write and a sample for the same channel in one cycle
   lose the sample's effect on the state; the setup logic is expected to
   write while the channel is quiet.
   The divider is combinational and sits on the sample path; at the
   block's clock rate this is acceptable, a faster clock would need it
   pipelined.

 Assumes scaled samples in display counts from the measurement front end
 and a configuration port driven by the panel's setup logic.
*/
`timescale 1ns/1ps
// How it works
// - Each channel holds a sample count from 1 to 255 for its average.
// - Each channel holds a window width from 1 to 65535 counts.
// - The window is compared in display counts, the units of the samples.
// - While samples stay in the window the output is the running average.
// - A sample outside the window is output raw at once.
// - Once the signal settles a new window is set and averaging resumes.
// - The last digit of the selection code picks the channel, 1 for channel 0.
module windowed_input_averager
   import averager_pkg::*;
#(
   parameter int N_CHAN = CHANNELS
) (
   input  wire logic                    clock,
   input  wire logic                    rst,
   input  wire averager_pkg::sample_type in_sample,
   input  wire logic                    in_valid,
   output logic                         in_ready,
   output averager_pkg::result_type     out_result,
   output logic                         out_valid,
   input  wire logic                    out_ready,
   input  wire averager_pkg::config_type cfg,
   input  wire logic                    cfg_write
);
   initial begin
      if (N_CHAN < 1 || N_CHAN > CHANNELS) $error("N_CHAN out of range");
   end

   sample_type                 fifo_q;
   logic                       fifo_valid;
   logic                       take;
   logic [COUNT_W-1:0]         count_r  [N_CHAN];
   logic [WIDTH_W-1:0]         width_r  [N_CHAN];
   logic signed [SAMPLE_W-1:0] ring_r   [N_CHAN][256];
   logic [COUNT_W-1:0]         head_r   [N_CHAN];
   logic [COUNT_W:0]           fill_r   [N_CHAN];
   logic signed [SUM_W-1:0]    sum_r    [N_CHAN];
   logic signed [SAMPLE_W-1:0] centre_r [N_CHAN];
   logic signed [SAMPLE_W-1:0] last_r   [N_CHAN];
   logic                       unset_r  [N_CHAN];
   result_type                 res_r;
   logic                       res_valid_r;

   sample_fifo #(.WIDTH($bits(sample_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock     (clock),
      .rst       (rst),
      .in_data   (in_sample),
      .in_valid  (in_valid),
      .in_ready  (in_ready),
      .out_data  (fifo_q),
      .out_valid (fifo_valid),
      .out_ready (take)
   );

   // Output register drains when empty or accepted; stalls the FIFO otherwise
   assign take       = fifo_valid && (!res_valid_r || out_ready);
   assign out_result = res_r;
   assign out_valid  = res_valid_r;

   wire [3:0]            cfg_idx = cfg.sel_digit - SEL_DIGIT_BASE;
   wire                  cfg_hit = cfg_write && cfg_idx < 4'(N_CHAN);
   wire                  cfg_ok  = cfg.avg_sample_count != '0 && cfg.avg_window_width != '0;
   wire [CH_W-1:0]       ch      = fifo_q.chan;
   wire signed [SAMPLE_W-1:0] x  = fifo_q.value;
   wire                  ch_ok   = 32'(ch) < N_CHAN;

   wire signed [SAMPLE_W:0] d_centre = SAMPLE_W'(x) - centre_r[ch];
   wire signed [SAMPLE_W:0] d_last   = SAMPLE_W'(x) - last_r[ch];
   wire [SAMPLE_W:0]     a_centre = d_centre[SAMPLE_W] ? -d_centre : d_centre;
   wire [SAMPLE_W:0]     a_last   = d_last[SAMPLE_W] ? -d_last : d_last;
   // half width either side of the centre
   // Unknown channels still index the state arrays, but ch_ok gates the flag,
   // so they stay raw and the window flag stays defined
   wire                  in_win   = ch_ok && !unset_r[ch] &&
                                    a_centre <= (SAMPLE_W+1)'(width_r[ch] >> 1);
   // settled when within one full width of the previous sample
   wire                  settled  = a_last <= (SAMPLE_W+1)'(width_r[ch]);
   // Average full once count samples have joined since the restart
   wire                  full     = fill_r[ch] >= (COUNT_W+1)'(count_r[ch]);
   wire signed [SAMPLE_W-1:0] oldest =
      ring_r[ch][COUNT_W'(head_r[ch] - count_r[ch])];
   // Sum gains the new sample and drops the one leaving the average
   wire signed [SUM_W-1:0] sum_nxt = sum_r[ch] + SUM_W'(x) - (full ? SUM_W'(oldest) : '0);
   // Divisor is the number of samples in the average after this one
   wire [COUNT_W:0]      n_nxt    = full ? (COUNT_W+1)'(count_r[ch]) : fill_r[ch] + 1'b1;
   wire signed [SUM_W-1:0] avg    = sum_nxt / $signed({1'b0, n_nxt});

   // Per-channel state update
   generate
      for (genvar c = 0; c < N_CHAN; c++) begin : g_chan
         // Sample for this channel leaves the FIFO
         wire hit = take && ch_ok && 32'(ch) == c;

         // History ring, no reset needed: only read once written
         always_ff @(posedge clock) begin
            if (hit) ring_r[c][head_r[c]] <= x;
         end

         // Settings and window state of this channel
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               count_r[c]  <= COUNT_RESET;
               width_r[c]  <= WIDTH_RESET;
               head_r[c]   <= '0;
               fill_r[c]   <= '0;
               sum_r[c]    <= '0;
               centre_r[c] <= '0;
               last_r[c]   <= '0;
               unset_r[c]  <= 1'b1;
            end else begin
               if (cfg_hit && cfg_ok && 32'(cfg_idx) == c) begin
                  count_r[c] <= cfg.avg_sample_count;
                  width_r[c] <= cfg.avg_window_width;
                  fill_r[c]  <= '0;
                  sum_r[c]   <= '0;
                  unset_r[c] <= 1'b1;
               end else if (hit) begin
                  last_r[c] <= x;
                  head_r[c] <= head_r[c] + 1'b1;
                  if (in_win) begin
                     sum_r[c]  <= sum_nxt;
                     fill_r[c] <= n_nxt;
                  end else if (!unset_r[c] || settled) begin
                     // new window on settle, or raw while unsettled
                     unset_r[c]  <= !settled;
                     centre_r[c] <= x;
                     sum_r[c]    <= SUM_W'(x);
                     fill_r[c]   <= (COUNT_W+1)'(1);
                  end
               end
            end
         end
      end
   endgenerate

   // Output register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         res_r       <= '0;
         res_valid_r <= 1'b0;
      end else begin
         if (take) begin
            res_r.chan     <= ch;
            res_r.averaged <= in_win;
            res_r.value    <= in_win ? SAMPLE_W'(avg) : x;
            res_valid_r    <= 1'b1;
         end else if (out_ready) begin
            res_valid_r <= 1'b0;
         end
      end
   end
endmodule // windowed_input_averager

//--- sim/averager_checker.sv
/* Port assertions for the averager.
   Assumes a bind onto windowed_input_averager. */
`timescale 1ns/1ps
module averager_checker
   import averager_pkg::*;
#(parameter int N_CHAN = CHANNELS) (
   input wire logic                     clock,
   input wire logic                     rst,
   input wire averager_pkg::sample_type in_sample,
   input wire logic                     in_valid,
   input wire logic                     in_ready,
   input wire averager_pkg::result_type out_result,
   input wire logic                     out_valid,
   input wire logic                     out_ready
);
   logic [7:0] held_r; // Samples taken, not yet delivered
   // Count samples in flight
   always_ff @(posedge clock or posedge rst) begin
      if (rst) held_r <= 8'h00;
      else held_r <= held_r + 8'(in_valid && in_ready) - 8'(out_valid && out_ready);
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   a_hold_while_stalled: assert property (out_valid && !out_ready |=> out_valid && $stable(out_result))
      else $error("result changed while stalled");
   a_bad_chan_raw: assert property (out_valid && out_result.chan >= N_CHAN |-> !out_result.averaged)
      else $error("unknown channel averaged");
   a_no_spurious_out: assert property (out_valid |-> held_r != 8'h00)
      else $error("result without sample");
   a_empty_accepts: assert property (held_r == 8'h00 |-> in_ready)
      else $error("empty but not ready");
   a_full_only_drop: assert property ($fell(in_ready) |-> held_r >= 8'h08)
      else $error("ready dropped early");
   a_full_output_busy: assert property (!in_ready |-> out_valid || $past(out_valid && out_ready))
      else $error("full with idle output");
   a_reset_quiet: assert property ($fell(rst) |-> in_ready && !out_valid ##1 !out_valid)
      else $error("output after reset");
   a_last_out_drops: assert property (out_valid && out_ready && held_r == 8'h01 && !in_valid |=> !out_valid)
      else $error("extra result");
endmodule // averager_checker

//--- sim/front_end_model.sv
/* Measurement front end model offering samples.
   Assumes the bench fills q and seeds $urandom. */
`timescale 1ns/1ps
module front_end_model
   import averager_pkg::*;
(
   input  wire logic                 clock,
   input  wire logic                 slow,
   input  wire logic                 in_ready,
   output averager_pkg::sample_type in_sample,
   output logic                     in_valid
);
   sample_type q[$];
   logic took = 1'b0;
   logic v;
   initial begin
      in_valid = 1'b0;
      in_sample = '0;
   end
   // Note an accepted offer
   always @(posedge clock) took = in_valid && in_ready;
   // values in counts
   // Hold an offer until taken; idle data shows the inverse
   always @(negedge clock) begin
      if (took) void'(q.pop_front());
      v = (in_valid && !took) || (q.size() != 0 && !(slow && $urandom_range(1) == 0));
      in_valid <= v;
      in_sample <= v ? q[0] : ~in_sample;
   end
endmodule // front_end_model

//--- sim/windowed_input_averager_tb_top.sv
/* Random windowed averaging tests with stalls.
   Assumes the front end model and checker files. */
`timescale 1ns/1ps
module windowed_input_averager_tb_top;
   import averager_pkg::*;
   localparam int NCH = 3;
   logic clock = 0, rst = 1, out_ready = 0, cfg_write = 0, slow = 0, hold = 0;
   logic in_valid, in_ready, out_valid;
   sample_type in_sample;
   result_type out_result, exp_q[$];
   config_type cfg = '0;
   int errors = 0, check_count = 0, cycles = 0, cnt[4], wid[4];
   bit set[4], known[4];
   longint centre[4], last[4], hist[4][$];
   always #20 clock = ~clock;
   front_end_model fe (.clock(clock), .slow(slow), .in_ready(in_ready),
      .in_sample(in_sample), .in_valid(in_valid));
   windowed_input_averager #(.N_CHAN(NCH)) dut (.clock(clock), .rst(rst),
      .in_sample(in_sample), .in_valid(in_valid), .in_ready(in_ready),
      .out_result(out_result), .out_valid(out_valid), .out_ready(out_ready),
      .cfg(cfg), .cfg_write(cfg_write));
   task automatic check(string what, logic [25:0] seen, logic [25:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic result_type expect_of(sample_type s);
      result_type r;
      longint x, d, sum;
      int c;
      x = s.value;
      c = s.chan;
      r = '{chan: s.chan, averaged: 1'b0, value: s.value};
      if (c >= NCH) return r;
      d = x - centre[c];
      if (set[c] && (d < 0 ? -d : d) <= wid[c] / 2) begin
         hist[c].push_back(x);
         if (hist[c].size() > cnt[c]) void'(hist[c].pop_front());
         sum = 0;
         foreach (hist[c][i]) sum += hist[c][i];
         r.averaged = 1'b1;
         r.value = 24'(sum / hist[c].size());
      end else begin
         d = x - last[c];
         set[c] = known[c] && (d < 0 ? -d : d) <= wid[c];
         centre[c] = x;
         hist[c] = {x};
      end
      last[c] = x;
      known[c] = 1;
      return r;
   endfunction
   task automatic drain();
      for (int i = 0; i < 3000 && exp_q.size() != 0; i++) @(negedge clock);
   endtask
   task automatic configure(int d, int n, int w);
      drain();
      cfg = '{sel_digit: 4'(d), avg_sample_count: 8'(n), avg_window_width: 16'(w)};
      cfg_write = 1;
      @(negedge clock);
      cfg_write = 0;
      if (d >= 1 && d <= 4 && n != 0 && w != 0) begin
         cnt[d-1] = n;
         wid[d-1] = w;
         set[d-1] = 0;
      end
   endtask
   task automatic burst(int c, int n);
      longint lvl;
      sample_type s;
      lvl = $urandom_range(8_000_000) - 4_000_000;
      repeat (n) begin
         if ($urandom_range(7) == 0) lvl = $urandom_range(8_000_000) - 4_000_000;
         s.chan = 2'($urandom_range(5) == 0 ? 3 : c);
         s.value = 24'(lvl + $urandom_range(wid[c] / 2) - wid[c] / 4);
         exp_q.push_back(expect_of(s));
         fe.q.push_back(s);
         @(negedge clock);
      end
   endtask
   // Sink with random stalls
   always @(negedge clock) out_ready <= !hold && $urandom_range(3) != 0;
   always @(posedge clock) if (out_valid && out_ready) check("result", out_result, exp_q.pop_front());
   always @(posedge clock) begin
      cycles++;
      if (cycles == 30000) begin
         errors++;
         final_report();
      end
   end
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h3ac1_394e));
      foreach (cnt[i]) begin
         cnt[i] = 1;
         wid[i] = 65535;
         known[i] = 1; // Previous sample starts at zero after reset
      end
      repeat (12) @(negedge clock);
      rst = 0;
      for (int k = 0; k < 6; k++) begin
         slow = k[0];
         for (int d = 1; d <= 4; d++) begin
            configure(d, k == 0 ? 1 : k == 1 ? 255 : $urandom_range(255, 1),
               k == 0 ? 1 : k == 1 ? 65535 : $urandom_range(3000, 1));
            burst(d - 1, 40);
         end
      end
      configure(0, 5, 5);
      configure(2, 0, 9);
      burst(1, 30);
      $display("test settings and streams done");
      hold = 1;
      burst(0, 12);
      repeat (30) @(negedge clock);
      check("in_ready full", 26'(in_ready), 26'h000_0000);
      hold = 0;
      drain();
      check("pending", 26'(exp_q.size()), 26'h000_0000);
      $display("test fill and drain done");
      final_report();
   end
endmodule // windowed_input_averager_tb_top
bind windowed_input_averager averager_checker #(.N_CHAN(N_CHAN)) chk (.clock(clock), .rst(rst),
   .in_sample(in_sample), .in_valid(in_valid), .in_ready(in_ready),
   .out_result(out_result), .out_valid(out_valid), .out_ready(out_ready));
